// ### bench/qdt_encoder_model.sv
// Encoder model driving phase and index pins
`timescale 1ns/1ns
`default_nettype none
module qdt_encoder_model (
  input wire logic clock,
  output logic phase_a_pin = 1'h0,
  output logic phase_b_pin = 1'h0,
  output logic index_pin = 1'h0
);
  // Toggle selected phases, set index, hold past the input filter
  task automatic flip(input logic a, input logic b, input logic x);
    phase_a_pin <= phase_a_pin ^ a;
    phase_b_pin <= phase_b_pin ^ b;
    index_pin <= x;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### bench/qdt_timer_control_assertions.sv
// Port checks for the decoder timer control block
`timescale 1ns/1ns
`default_nettype none
`include "qdt_defs.vh"
module qdt_timer_control_assertions (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phase_b_pin,
  input wire logic irq,
  input wire logic count_direction_out
);
  // Access phase taken at this edge
  wire take = psel && penable && !pready;
  reg [15:0] ctrl_q;
  reg [15:0] mask_q;
  // Shadow control and mask words as software writes them
  always @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= 16'h0000;
      mask_q <= 16'h0000;
    end else if (take && pwrite && paddr == `QDT_OFF_CTRL) begin
      ctrl_q <= pwdata[15:0] & `QDT_CTRL_WMASK;
    end else if (take && pwrite && paddr == `QDT_OFF_MASK) begin
      mask_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_ready_after_access: assert property (take |=> pready) else $error("no pready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("long pready");
  a_ready_unasked: assert property (!(psel && penable) |=> !pready) else $error("stray pready");
  a_err_unmapped: assert property (take && paddr > `QDT_OFF_MASK |=> pslverr) else $error("no pslverr");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_dir_from_pin:
    assert property ((ctrl_q[10:8] == 3'h1 && ctrl_q[0] && $stable(phase_b_pin)) [*7]
      |-> count_direction_out == phase_b_pin) else $error("direction not pin");
  a_dir_from_bit:
    assert property ((ctrl_q[10:8] == 3'h1 && !ctrl_q[0] && $stable(ctrl_q)) [*3]
      |-> count_direction_out == ctrl_q[11]) else $error("direction not bit");
  a_irq_masked_off: assert property ((mask_q == 16'h0000) [*3] |-> !irq) else $error("irq while masked");
endmodule
bind qdt_timer_control qdt_timer_control_assertions i_chk (
  .clock(clock),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .phase_b_pin(phase_b_pin),
  .irq(irq),
  .count_direction_out(count_direction_out)
);
`default_nettype wire

// ### bench/test_quad_decoder_timer_control.sv
// Bench for the decoder timer control block
`timescale 1ns/1ns
`default_nettype none
`include "qdt_defs.vh"
module test_quad_decoder_timer_control;
  logic clock = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, gate_pin = 1'h0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'hf;
  wire [31:0] prdata;
  wire pready, pslverr, phase_a_pin, phase_b_pin, index_pin, irq, count_direction_out;
  int n_mismatch = 0, checked = 0, cyc = 0;
  qdt_timer_control i_qdt_timer_control (
    .clock(clock),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .index_pin(index_pin),
    .gate_pin(gate_pin),
    .irq(irq),
    .count_direction_out(count_direction_out)
  );
  qdt_encoder_model i_qdt_encoder_model (
    .clock(clock),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .index_pin(index_pin)
  );
  initial forever #4 clock = ~clock;
  // Count a comparison, report a mismatch
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1 && cyc < 20000);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Reset value, read-only zero bits, unmapped read
  task automatic t_regs;
    rc(`QDT_OFF_CTRL, 32'h0);
    wr(`QDT_OFF_CTRL, 32'hfffff8ff);
    rc(`QDT_OFF_CTRL, 32'h083f);
    rc(12'h040, 32'h0);
    chk(er, 1'h1);
  endtask
  // Every prescale code in timer mode
  task automatic t_prescale;
    int dv[4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++) begin
      wr(`QDT_OFF_CTRL, 32'h0900 | (c << 3));
      wr(`QDT_OFF_TMR, 32'h0);
      tk(dv[c] * 8);
      apb(1'h0, `QDT_OFF_TMR, 32'h0);
      chk(rd > 6 && rd < 15, 1'h1);
    end
  endtask
  // Phase A rising edges clock the timer
  task automatic t_pin_clock;
    wr(`QDT_OFF_CTRL, 32'h0902);
    wr(`QDT_OFF_TMR, 32'h0);
    repeat (10) i_qdt_encoder_model.flip(1'h1, 1'h0, 1'h0);
    rc(`QDT_OFF_TMR, 32'h5);
  endtask
  // Gated accumulation, then gating switched off
  task automatic t_gate;
    wr(`QDT_OFF_CTRL, 32'h0920);
    wr(`QDT_OFF_TMR, 32'h0);
    tk(40);
    rc(`QDT_OFF_TMR, 32'h0);
    gate_pin <= 1'h1;
    tk(40);
    apb(1'h0, `QDT_OFF_TMR, 32'h0);
    chk(rd > 30 && rd < 48, 1'h1);
    gate_pin <= 1'h0;
    wr(`QDT_OFF_CTRL, 32'h0900);
    tk(40);
    apb(1'h0, `QDT_OFF_TMR, 32'h0);
    chk(rd > 70, 1'h1);
    // Free-running up count out of all ones raises the wrap event
    wr(`QDT_OFF_STAT, 32'h7);
    wr(`QDT_OFF_TMR, 32'hfffe);
    tk(4);
    rc(`QDT_OFF_STAT, 32'h4);
    wr(`QDT_OFF_STAT, 32'h4);
  endtask
  // Index pulse clears position only where enabled
  task automatic t_index;
    logic [15:0] c[4] = '{16'h0404, 16'h0604, 16'h0704, 16'h0400};
    for (int k = 0; k < 4; k++) begin
      wr(`QDT_OFF_CTRL, {16'h0, c[k]});
      wr(`QDT_OFF_POS, 32'h1234);
      i_qdt_encoder_model.flip(1'h0, 1'h0, 1'h1);
      i_qdt_encoder_model.flip(1'h0, 1'h0, 1'h0);
      rc(`QDT_OFF_POS, k < 2 ? 32'h0 : 32'h1234);
    end
    // Index edges in quadrature modes leave the index event set
    rc(`QDT_OFF_STAT, 32'h1);
  endtask
  // Count error flag, interrupt raised, masked, cleared
  task automatic t_error;
    for (int m = 5; m < 7; m++) begin
      wr(`QDT_OFF_CTRL, m << 8);
      wr(`QDT_OFF_STAT, 32'h7);
      wr(`QDT_OFF_MASK, 32'h2);
      repeat (2) i_qdt_encoder_model.flip(1'h1, 1'h1, 1'h0);
      rc(`QDT_OFF_STAT, m == 6 ? 32'h2 : 32'h0);
      chk(irq, m == 6);
      wr(`QDT_OFF_MASK, 32'h0);
      tk(1);
      chk(irq, 1'h0);
      wr(`QDT_OFF_STAT, 32'h2);
      rc(`QDT_OFF_STAT, 32'h0);
    end
  endtask
  // Direction from phase B level, then from the direction bit
  task automatic t_dir;
    wr(`QDT_OFF_CTRL, 32'h0101);
    i_qdt_encoder_model.flip(1'h0, 1'h1, 1'h0);
    chk(count_direction_out, 1'h1);
    i_qdt_encoder_model.flip(1'h0, 1'h1, 1'h0);
    chk(count_direction_out, 1'h0);
    wr(`QDT_OFF_CTRL, 32'h0900);
    tk(2);
    chk(count_direction_out, 1'h1);
  endtask
  // Reverse steps ending with phase B high still count down
  task automatic t_quad;
    wr(`QDT_OFF_CTRL, 32'h0601);
    wr(`QDT_OFF_POS, 32'h0);
    for (int k = 0; k < 5; k++) i_qdt_encoder_model.flip(k[0], !k[0], 1'h0);
    chk(count_direction_out, 1'h0);
    rc(`QDT_OFF_POS, 32'hfffb);
  endtask
  // Counts and verdict
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // Main sequence
  initial begin
    tk(10);
    nrst <= 1'h1;
    t_regs;
    t_prescale;
    t_pin_clock;
    t_gate;
    t_index;
    t_error;
    t_dir;
    t_quad;
    end_of_test;
  end
endmodule
`default_nettype wire

// ### include/qdt_defs.vh
// Register offsets, field positions, reset values and codes for the decoder timer control block
`ifndef QDT_DEFS_VH
`define QDT_DEFS_VH
`define QDT_OFF_CTRL 12'h000
`define QDT_OFF_POS 12'h004
`define QDT_OFF_TMR 12'h008
`define QDT_OFF_STAT 12'h00c
`define QDT_OFF_MASK 12'h010
`define QDT_BIT_DIR_SRC 0
`define QDT_BIT_TCLK_SRC 1
`define QDT_BIT_IDX_RST 2
`define QDT_PS_LO 3
`define QDT_PS_HI 4
`define QDT_BIT_GATE 5
`define QDT_MODE_LO 8
`define QDT_MODE_HI 10
`define QDT_BIT_DIR 11
`define QDT_CTRL_RESET 16'h0000
`define QDT_CTRL_WMASK 16'h0f3f
`define QDT_MODE_TIMER 3'h1
`define QDT_MODE_X2_IDX 3'h4
`define QDT_MODE_X4_IDX 3'h6
`define QDT_PS_DIV1 8'h00
`define QDT_PS_DIV8 8'h07
`define QDT_PS_DIV64 8'h3f
`define QDT_PS_DIV256 8'hff
`define QDT_EV_INDEX 0
`define QDT_EV_COUNT_ERROR_FLAG 1
`define QDT_EV_TMRWRAP 2
`define QDT_EV_W 3
`endif

// ### rtl/qdt_timer_control.v
// Quadrature decoder timer, prescaler, index reset and direction control with APB registers
`timescale 1ns/1ns
`default_nettype none
`include "qdt_defs.vh"
module qdt_timer_control #(
  // Width of the position counter and of the timer
  parameter CNT_W = 16
) (
  // Clock and synchronous active-low reset
  input wire clock,
  input wire nrst,
  // APB slave port
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Encoder phases, index pulse and timer gate, all asynchronous
  input wire phase_a_pin,
  input wire phase_b_pin,
  input wire index_pin,
  input wire gate_pin,
  // Level interrupt and current counting direction
  output reg irq,
  output reg count_direction_out
);
  // Structure: the four pins are filtered first; phase A, phase B and index are then turned into single-cycle
  // edge strobes. The strobes feed the quadrature decoder, the position counter
  // and the timer. Software sees one control word, the two counters, a sticky
  // status word and its mask, the first three as 16-bit registers and the last two as 3-bit ones, all in the low half of the bus.
  // Every counting decision is taken from filtered levels only, so a glitch
  // shorter than one clock period on a pin never reaches the counters.
  //
  // Register map, byte addresses:
  //   0x000 control word
  //   0x004 position counter
  //   0x008 timer
  //   0x00c status, write one to clear
  //   0x010 interrupt mask, same layout as status
  // Status bits: 0 index edge in a quadrature mode, 1 count error in an index
  // mode, 2 timer wrap while counting up
  //
  // Pin synchronisers, three stages each
  reg [2:0] a_sync_q;
  reg [2:0] b_sync_q;
  reg [2:0] i_sync_q;
  reg [2:0] g_sync_q;

  // Stage one may go metastable; only stage two reads it
  // Filtered pin levels, changed once stages two and three agree
  reg a_lvl_q;
  reg b_lvl_q;
  reg i_lvl_q;
  reg g_lvl_q;

  // Control register and counters
  // The control word keeps its read-only bits at zero through the write mask
  reg [15:0] position_decoder_control_q;
  reg [CNT_W-1:0] position_counter_q;
  reg [CNT_W-1:0] timer_q;
  reg [7:0] pre_q;
  reg [`QDT_EV_W-1:0] stat_q;
  reg [`QDT_EV_W-1:0] mask_q;

  // Decoded fields
  // Each field is a plain slice of the control word, no extra state
  wire [2:0] decoder_mode_field = position_decoder_control_q[`QDT_MODE_HI:`QDT_MODE_LO];
  wire gated_accum_enable = position_decoder_control_q[`QDT_BIT_GATE];
  wire [1:0] timer_prescale_select = position_decoder_control_q[`QDT_PS_HI:`QDT_PS_LO];
  wire index_reset_enable = position_decoder_control_q[`QDT_BIT_IDX_RST];
  wire timer_clock_source = position_decoder_control_q[`QDT_BIT_TCLK_SRC];
  wire direction_source_select = position_decoder_control_q[`QDT_BIT_DIR_SRC];
  wire count_direction_bit = position_decoder_control_q[`QDT_BIT_DIR];
  // Index-capable modes 100 and 110; the index reset enable and the count
  // error flag mean nothing in any other mode
  wire idx_mode = (decoder_mode_field == `QDT_MODE_X2_IDX) || (decoder_mode_field == `QDT_MODE_X4_IDX);
  // Quadrature modes are 1xx; timer mode is 001
  // Mode 000 and the remaining codes leave both counters still
  wire quad_mode = decoder_mode_field[2];
  wire tmr_mode = (decoder_mode_field == `QDT_MODE_TIMER);

  // Prescale terminal count for a code
  // The prescaler counts from zero up to this value, so a terminal count of
  // N-1 gives a divide by N; code 00 gives a tick on every source event
  function [7:0] qdt_ps_max;
    input [1:0] code;
    begin
      case (code)
        2'h3: qdt_ps_max = `QDT_PS_DIV256;
        2'h2: qdt_ps_max = `QDT_PS_DIV64;
        2'h1: qdt_ps_max = `QDT_PS_DIV8;
        default: qdt_ps_max = `QDT_PS_DIV1;
      endcase
    end
  endfunction

  // Synchronise and filter pins
  // A pin change reaches the filtered level four clock edges later: three to
  // shift through the stages and one more for the agreement test. Pins must
  // therefore stay at a level for at least two cycles to be seen.
  always @(posedge clock) begin
    if (!nrst) begin
      a_sync_q <= 3'h0;
      b_sync_q <= 3'h0;
      i_sync_q <= 3'h0;
      g_sync_q <= 3'h0;
      a_lvl_q <= 1'b0;
      b_lvl_q <= 1'b0;
      i_lvl_q <= 1'b0;
      g_lvl_q <= 1'b0;
    end else begin
      // Shift each pin into its three-stage chain
      a_sync_q <= {a_sync_q[1:0], phase_a_pin};
      b_sync_q <= {b_sync_q[1:0], phase_b_pin};
      i_sync_q <= {i_sync_q[1:0], index_pin};
      g_sync_q <= {g_sync_q[1:0], gate_pin};
      // Take a new level only once stages two and three agree
      if (a_sync_q[1] == a_sync_q[2]) begin
        a_lvl_q <= a_sync_q[2];
      end
      if (b_sync_q[1] == b_sync_q[2]) begin
        b_lvl_q <= b_sync_q[2];
      end
      if (i_sync_q[1] == i_sync_q[2]) begin
        i_lvl_q <= i_sync_q[2];
      end
      if (g_sync_q[1] == g_sync_q[2]) begin
        g_lvl_q <= g_sync_q[2];
      end
    end
  end

  // Previous filtered levels for edge detection
  // These reset to zero, the idle level of every pin, so no false edge is
  // seen right after reset while the filters fill
  reg a_prev_q;
  reg b_prev_q;
  reg i_prev_q;
  always @(posedge clock) begin
    if (!nrst) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      i_prev_q <= 1'b0;
    end else begin
      a_prev_q <= a_lvl_q;
      b_prev_q <= b_lvl_q;
      i_prev_q <= i_lvl_q;
    end
  end
  // Single-cycle strobes from the filtered levels
  wire a_rise = a_lvl_q & ~a_prev_q;
  wire a_chg = a_lvl_q ^ a_prev_q;
  wire b_chg = b_lvl_q ^ b_prev_q;
  wire i_rise = i_lvl_q & ~i_prev_q;

  // Quadrature step and decoded direction (x4 counts both phases, x2 only A)
  // Forward motion has phase A leading phase B. After a change of phase A the
  // phases differ when moving forward; after a change of phase B they agree.
  // The decoded direction is only meaningful in a cycle with a step.
  wire quad_step = quad_mode & (a_chg | (decoder_mode_field[1] & b_chg));
  wire quad_up = a_chg ? (a_lvl_q ^ b_lvl_q) : ~(a_lvl_q ^ b_lvl_q);
  // Illegal transition: both phases changed in one cycle
  // An illegal step never moves the position counter
  wire quad_err = quad_mode & a_chg & b_chg;

  // Direction selection
  // In quadrature modes the direction source bit is a don't-care; between steps
  // the last decoded direction, kept in the direction bit, stands
  reg dir_up;
  always @* begin
    if (quad_mode) begin
      // Decoded direction on a step, otherwise the stored one
      dir_up = quad_step ? quad_up : count_direction_bit;
    end else if (direction_source_select) begin
      dir_up = b_lvl_q;
    end else begin
      dir_up = count_direction_bit;
    end
  end

  // Timer tick source and prescale
  // A source event is either every clock or one filtered rising edge of phase A.
  // Gating and the prescaler both act on source events, so with the gate low
  // the prescaler holds its phase and the timer keeps its count.
  wire src_tick = timer_clock_source ? a_rise : 1'b1;
  wire [7:0] ps_max = tmr_mode ? qdt_ps_max(timer_prescale_select) : `QDT_PS_DIV1;
  wire gate_ok = ~gated_accum_enable | g_lvl_q;
  wire pre_tick = src_tick & gate_ok & (pre_q >= ps_max);
  wire tmr_run = tmr_mode & src_tick & gate_ok;
  wire tmr_wrap = pre_tick & tmr_run & dir_up & (timer_q == {CNT_W{1'b1}});

  // APB decode
  // A transfer is taken in the first access cycle only; the registered ready
  // keeps the second access cycle from being taken again. Addresses are full
  // byte addresses, so an unaligned or unmapped address hits nothing.
  wire acc = psel & penable & ~pready;
  wire wr_en = acc & pwrite;
  wire hit_ctrl = (paddr == `QDT_OFF_CTRL);
  wire hit_pos = (paddr == `QDT_OFF_POS);
  wire hit_tmr = (paddr == `QDT_OFF_TMR);
  wire hit_stat = (paddr == `QDT_OFF_STAT);
  wire hit_mask = (paddr == `QDT_OFF_MASK);
  wire hit_any = hit_ctrl | hit_pos | hit_tmr | hit_stat | hit_mask;
  // Byte lanes zero and one carry the 16-bit registers
  wire [15:0] wlane = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
  wire [15:0] wsel = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Control register: software write first, then the decoded direction
  // In quadrature modes each step stores the decoded direction in the direction
  // bit, so software can read which way the encoder last moved
  always @(posedge clock) begin
    if (!nrst) begin
      position_decoder_control_q <= `QDT_CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      position_decoder_control_q <= (position_decoder_control_q & ~(wsel & `QDT_CTRL_WMASK))
                                    | (wlane & wsel & `QDT_CTRL_WMASK);
    end else if (quad_mode && quad_step) begin
      // Quadrature modes report the decoded direction in the direction bit of the control word
      position_decoder_control_q[`QDT_BIT_DIR] <= quad_up;
    end
  end

  // Position counter: index reset, quadrature count, software write
  // Priority is software write, then index reset, then counting; an index
  // edge that lands on a counting step therefore leaves the counter at zero
  always @(posedge clock) begin
    if (!nrst) begin
      position_counter_q <= {CNT_W{1'b0}};
    end else if (wr_en && hit_pos) begin
      position_counter_q <= wlane[CNT_W-1:0];
    end else if (idx_mode && index_reset_enable && i_rise) begin
      position_counter_q <= {CNT_W{1'b0}};
    end else if (quad_step && !quad_err) begin
      // One count per legal step, in the selected direction
      position_counter_q <= dir_up ? position_counter_q + 1'b1 : position_counter_q - 1'b1;
    end
  end

  // Prescaler and timer
  // The prescaler only advances on source events that pass the gate, and
  // restarts from zero on the tick it gives; a software write to the timer
  // does not touch the prescaler phase
  always @(posedge clock) begin
    if (!nrst) begin
      pre_q <= 8'h00;
      timer_q <= {CNT_W{1'b0}};
    end else begin
      // Prescaler phase
      if (tmr_run) begin
        pre_q <= pre_tick ? 8'h00 : pre_q + 8'h01;
      end
      // Software write wins over a count
      if (wr_en && hit_tmr) begin
        timer_q <= wlane[CNT_W-1:0];
      end else if (tmr_run && pre_tick) begin
        // Holds while gate is low, since tmr_run drops
        timer_q <= dir_up ? timer_q + 1'b1 : timer_q - 1'b1;
      end
    end
  end

  // Events: index, count error (only in index modes), timer wrap
  // Each event is a single-cycle strobe; the wrap event is the up count out
  // of the all-ones value
  wire [`QDT_EV_W-1:0] ev;
  assign ev[`QDT_EV_INDEX] = quad_mode & i_rise;
  assign ev[`QDT_EV_COUNT_ERROR_FLAG] = idx_mode & quad_err;
  assign ev[`QDT_EV_TMRWRAP] = tmr_wrap;

  // Sticky status, write one to clear; a new event wins over the clear
  // Giving the event priority means software never loses an event that lands
  // in the same cycle as its clear. Only byte lane zero holds status bits.
  always @(posedge clock) begin
    if (!nrst) begin
      stat_q <= {`QDT_EV_W{1'b0}};
      mask_q <= {`QDT_EV_W{1'b0}};
    end else begin
      // Clear the written ones, then merge this cycle's events
      if (wr_en && hit_stat && pstrb[0]) begin
        stat_q <= (stat_q & ~pwdata[`QDT_EV_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      // Mask takes the low status bits as written
      if (wr_en && hit_mask && pstrb[0]) begin
        mask_q <= pwdata[`QDT_EV_W-1:0];
      end
    end
  end

  // Read mux
  // Unmapped addresses read as zero; upper bus bits are always zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (hit_ctrl) begin
      rd_d[15:0] = position_decoder_control_q;
    end else if (hit_pos) begin
      rd_d[CNT_W-1:0] = position_counter_q;
    end else if (hit_tmr) begin
      rd_d[CNT_W-1:0] = timer_q;
    end else if (hit_stat) begin
      rd_d[`QDT_EV_W-1:0] = stat_q;
    end else if (hit_mask) begin
      rd_d[`QDT_EV_W-1:0] = mask_q;
    end
  end

  // APB answer one cycle into the access phase, registered outputs
  // Every output comes straight from a flip-flop, so the interrupt and the
  // direction output lag their sources by one cycle. Read data is captured
  // when the transfer is taken and holds until the next read.
  always @(posedge clock) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
      count_direction_out <= 1'b0;
    end else begin
      // Ready and error pulse for one cycle after a taken transfer
      pready <= acc;
      pslverr <= acc & ~hit_any;
      if (acc && !pwrite) begin
        prdata <= rd_d;
      end
      irq <= |(stat_q & mask_q);
      count_direction_out <= dir_up;
    end
  end
endmodule
`default_nettype wire
